// ==== dv/pwmpd_core_test.sv ====
// Testbench: registers, buffered load, generator and pin routing
`timescale 1ns/1ps
`default_nettype none
module pwmpd_core_test;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    pwmpd_pkg::pwmpd_sfr_t sfr = '0;
    logic                  ovf = 1'b0;
    logic                  tmr_en = 1'b0;
    logic [2:0]            psc = 3'h0;
    logic [5:0]            pout = 6'h00;
    logic [5:0]            poe = 6'h00;
    logic [7:0]            rdata;
    logic [5:0]            pdat;
    logic [5:0]            pen;
    logic [5:0]            lvl;
    logic [5:0]            gsig;
    int                    hg [6];
    logic                  mon_v = 1'b0;
    logic [7:0]            expq [$];
    int                    err_total = 0;
    int                    n_checks = 0;
    int                    tc = 0;
    int                    f;
    int                    hi [6];
    logic [15:0]           duty [6];
    // ----------------------------------------
    // Clock, overflow source, instances
    // ----------------------------------------
    always #10 clk = ~clk;
    always @(negedge clk) begin
        tc <= (tc == 2) ? 0 : tc + 1;
        ovf <= tmr_en && (tc == 0);
    end
    pwmpd_core pwmpd_core_inst (.i_clk_sys(clk), .i_rst(rst), .i_sfr(sfr), .i_timer1_ovf(ovf),
        .i_clock_prescale_code(psc), .i_port_out(pout), .i_port_oe(poe), .o_sfr_rdata(rdata),
        .o_generator_output_signal(gsig), .o_pin_data(pdat), .o_pin_oe(pen));
    pwmpd_load pwmpd_load_inst (.i_pin_data(pdat), .i_pin_oe(pen), .o_level(lvl));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pg);
        @(negedge clk);
        sfr <= '{addr: a, wr: 1'b1, wdata: d, page: pg};
        @(negedge clk);
        sfr.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic pg, input logic [7:0] e);
        @(negedge clk);
        sfr <= '{addr: a, wr: 1'b0, wdata: 8'h00, page: pg};
        expq.push_back(e);
        @(negedge clk);
        mon_v <= 1'b1;
        @(negedge clk);
        mon_v <= 1'b0;
    endtask : rd
    task automatic count(input int cyc);
        hi = '{default: 0};
        hg = '{default: 0};
        repeat (cyc) begin
            @(negedge clk);
            for (int c = 0; c < 6; c++) begin
                hi[c] += lvl[c];
                hg[c] += gsig[c];
            end
        end
    endtask : count
    task automatic chk_cnt(input logic [15:0] lim, input logic [15:0] mul);
        for (int c = 0; c < 6; c++) begin
            chk(16'(hi[c]), 16'((duty[c] > lim ? lim : duty[c]) * mul));
            chk(16'(hg[c]), 16'((duty[c] > lim ? lim : duty[c]) * mul));
        end
    endtask : chk_cnt
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------
    // Read-data monitor
    // ----------------------------------------
    always @(negedge clk) begin
        if (mon_v) begin
            chk({8'h00, rdata}, {8'h00, expq.pop_front()});
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #400_000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        void'($urandom(17));
        repeat (8) @(negedge clk);
        rst <= 1'b0;
        rd(pwmpd_pkg::ADDR_CLOCK_CONTROL, 1'b0, 8'h00);
        rd(pwmpd_pkg::ADDR_PERIOD_LOW, 1'b0, 8'h00);
        rd(pwmpd_pkg::ADDR_PERIOD_HIGH, 1'b0, 8'h00);
        rd(pwmpd_pkg::ADDR_PIN_SELECT, 1'b0, 8'h00);
        for (int c = 0; c < 6; c++) begin
            rd(pwmpd_pkg::ADDR_DUTY_HIGH[c], 1'b1, 8'h00);
            rd(pwmpd_pkg::ADDR_DUTY_LOW[c], 1'b1, 8'h00);
        end
        $display("Test reset values done");
        wr(pwmpd_pkg::ADDR_CLOCK_CONTROL, 8'hFF, 1'b0);
        rd(pwmpd_pkg::ADDR_CLOCK_CONTROL, 1'b0, 8'h40);
        wr(pwmpd_pkg::ADDR_PIN_SELECT, 8'hFF, 1'b0);
        rd(pwmpd_pkg::ADDR_PIN_SELECT, 1'b0, 8'h3F);
        wr(pwmpd_pkg::ADDR_DUTY_HIGH[4], 8'h5A, 1'b0);
        rd(pwmpd_pkg::ADDR_DUTY_HIGH[4], 1'b0, 8'h00);
        rd(pwmpd_pkg::ADDR_DUTY_HIGH[4], 1'b1, 8'h00);
        rd(8'h80, 1'b0, 8'h00);
        $display("Test access and paging done");
        wr(pwmpd_pkg::ADDR_PERIOD_LOW, 8'h05, 1'b0);
        wr(pwmpd_pkg::ADDR_PERIOD_HIGH, 8'h00, 1'b0);
        rd(pwmpd_pkg::ADDR_PERIOD_LOW, 1'b0, 8'h05);
        for (int c = 0; c < 6; c++) begin
            duty[c] = 16'($urandom_range(7, 0));
            wr(pwmpd_pkg::ADDR_DUTY_HIGH[c], duty[c][15:8], 1'b1);
            wr(pwmpd_pkg::ADDR_DUTY_LOW[c], duty[c][7:0], 1'b1);
            rd(pwmpd_pkg::ADDR_DUTY_LOW[c], 1'b1, duty[c][7:0]);
        end
        wr(pwmpd_pkg::ADDR_CLOCK_CONTROL, 8'h00, 1'b0);
        wr(pwmpd_pkg::ADDR_RUN_CONTROL, 8'h40, 1'b0);
        repeat (20) @(negedge clk);
        rd(pwmpd_pkg::ADDR_RUN_CONTROL, 1'b0, 8'h40);
        count(24);
        chk_cnt(16'h0000, 16'h0000);
        wr(pwmpd_pkg::ADDR_RUN_CONTROL, 8'hC0, 1'b0);
        for (int k = 0; k < 9; k++) begin
            f = (k == 8) ? 3 : (1 << k);
            psc <= (k == 8) ? 3'h0 : 3'(k);
            tmr_en <= (k == 8);
            wr(pwmpd_pkg::ADDR_CLOCK_CONTROL, (k == 8) ? 8'h40 : 8'h00, 1'b0);
            repeat (12 * f + 4) @(negedge clk);
            if (k == 0) rd(pwmpd_pkg::ADDR_RUN_CONTROL, 1'b0, 8'h80);
            count(6 * f);
            chk_cnt(16'h0006, 16'(f));
        end
        wr(pwmpd_pkg::ADDR_PERIOD_LOW, 8'h03, 1'b0);
        wr(pwmpd_pkg::ADDR_RUN_CONTROL, 8'hC0, 1'b0);
        repeat (40) @(negedge clk);
        rd(pwmpd_pkg::ADDR_RUN_CONTROL, 1'b0, 8'h80);
        count(12);
        chk_cnt(16'h0004, 16'h0003);
        $display("Test generator done");
        @(negedge clk);
        pout <= 6'($urandom());
        poe <= 6'($urandom());
        for (int k = 0; k < 2; k++) begin
            wr(pwmpd_pkg::ADDR_PIN_SELECT, (k == 0) ? 8'h20 : 8'h00, 1'b0);
            repeat (3) @(negedge clk);
            chk({10'h000, pen}, {10'h000, poe | ((k == 0) ? 6'h20 : 6'h00)});
            chk({10'h000, lvl & ((k == 0) ? 6'h1F : 6'h3F)}, {10'h000, pout & poe & ((k == 0) ? 6'h1F : 6'h3F)});
        end
        $display("Test pin routing done");
        summarize();
    end
endmodule : pwmpd_core_test
`default_nettype wire

// ==== dv/pwmpd_load.sv ====
// Load model: pin levels seen by the external power stage
`timescale 1ns/1ps
`default_nettype none
module pwmpd_load (
    input  wire logic [5:0] i_pin_data,
    input  wire logic [5:0] i_pin_oe,
    output logic      [5:0] o_level
);
    // ----------------------------------------
    // Pin resolution
    // ----------------------------------------
    // Undriven pins fall to the pull-down level
    always_comb o_level = i_pin_data & i_pin_oe;
endmodule : pwmpd_load
`default_nettype wire

// ==== src/pwmpd_core.sv ====
// Module: period, duty, clock source and pin routing of a six-channel pulse-width generator
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Bit 6 picks system clock or Timer 1
// - Shared 16-bit period from low/high bytes
// - Per-channel 16-bit duty from two bytes
// - Channels 4 and 5 duty only on page 1
// - Period, duties, pin select reset to zero
// - Low six bits route channel onto pin
// - Bit 5 routes channel 5; bits 7:6 unused
// - Load copies at period end, then self-clears
// - Prescale code divides by one to 128
// - Counter idles unless run enable set
module pwmpd_core (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    input  wire pwmpd_pkg::pwmpd_sfr_t i_sfr,
    input  wire logic                  i_timer1_ovf,
    input  wire logic [2:0]            i_clock_prescale_code,
    input  wire logic [5:0]            i_port_out,
    input  wire logic [5:0]            i_port_oe,
    output logic      [7:0]            o_sfr_rdata,
    output logic      [5:0]            o_generator_output_signal,
    output logic      [5:0]            o_pin_data,
    output logic      [5:0]            o_pin_oe
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic pwmpd_pkg::pwmpd_duty_dec_t duty_decode(input logic [7:0] addr, input logic page);
        pwmpd_pkg::pwmpd_duty_dec_t r;
        r = '0;
        for (int c = 0; c < pwmpd_pkg::NUM_CH; c++) begin
            if (c < pwmpd_pkg::FIRST_PAGED_CH || page == pwmpd_pkg::PAGE_ONE) begin
                if (addr == pwmpd_pkg::ADDR_DUTY_HIGH[c]) begin
                    r.hit  = 1'b1;
                    r.high = 1'b1;
                    r.ch   = 3'(c);
                end
                if (addr == pwmpd_pkg::ADDR_DUTY_LOW[c]) begin
                    r.hit  = 1'b1;
                    r.high = 1'b0;
                    r.ch   = 3'(c);
                end
            end
        end
        return r;
    endfunction : duty_decode

    function automatic logic [6:0] div_mask(input logic [2:0] code);
        return 7'((pwmpd_pkg::DIV_ONE << code) - pwmpd_pkg::DIV_ONE);
    endfunction : div_mask

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic        clk_src_q;
    logic        run_q;
    logic        load_q;
    logic [7:0]  period_low_q;
    logic [7:0]  period_high_q;
    logic [7:0]  duty_high_q [6];
    logic [7:0]  duty_low_q  [6];
    logic [5:0]  pin_sel_q;
    logic [15:0] period_buf_q;
    logic [15:0] duty_buf_q  [6];
    logic [15:0] cnt_q;
    logic [6:0]  div_cnt_q;
    logic [5:0]  gen_q;

    pwmpd_pkg::pwmpd_duty_dec_t wdec;
    pwmpd_pkg::pwmpd_duty_dec_t rdec;
    logic        wr_clk;
    logic        wr_run;
    logic        load_wr;
    logic        src_tick;
    logic        tick;
    logic        period_end;

    assign wdec       = duty_decode(i_sfr.addr, i_sfr.page);
    assign rdec       = wdec;
    assign wr_clk     = i_sfr.wr && i_sfr.addr == pwmpd_pkg::ADDR_CLOCK_CONTROL;
    assign wr_run     = i_sfr.wr && i_sfr.addr == pwmpd_pkg::ADDR_RUN_CONTROL;
    assign load_wr    = wr_run && i_sfr.wdata[pwmpd_pkg::BIT_LOAD];

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            clk_src_q <= 1'b0;
        end else if (wr_clk) begin
            clk_src_q <= i_sfr.wdata[pwmpd_pkg::BIT_CLK_SRC];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            run_q <= 1'b0;
        end else if (wr_run) begin
            run_q <= i_sfr.wdata[pwmpd_pkg::BIT_RUN];
        end
    end

    // Load request: set by write wins over hardware clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            load_q <= 1'b0;
        end else if (load_wr) begin
            load_q <= 1'b1;
        end else if (period_end) begin
            load_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            period_low_q  <= pwmpd_pkg::RST_BYTE;
            period_high_q <= pwmpd_pkg::RST_BYTE;
        end else if (i_sfr.wr) begin
            if (i_sfr.addr == pwmpd_pkg::ADDR_PERIOD_LOW) begin
                period_low_q <= i_sfr.wdata;
            end
            if (i_sfr.addr == pwmpd_pkg::ADDR_PERIOD_HIGH) begin
                period_high_q <= i_sfr.wdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_sel_q <= pwmpd_pkg::RST_SEL;
        end else if (i_sfr.wr && i_sfr.addr == pwmpd_pkg::ADDR_PIN_SELECT) begin
            pin_sel_q <= i_sfr.wdata[5:0];
        end
    end

    // ----------------------------------------
    // Per-channel duty bytes, buffers and outputs
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < pwmpd_pkg::NUM_CH; g++) begin : g_ch
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    duty_high_q[g] <= pwmpd_pkg::RST_BYTE;
                    duty_low_q[g]  <= pwmpd_pkg::RST_BYTE;
                end else if (i_sfr.wr && wdec.hit && wdec.ch == 3'(g)) begin
                    if (wdec.high) begin
                        duty_high_q[g] <= i_sfr.wdata;
                    end else begin
                        duty_low_q[g] <= i_sfr.wdata;
                    end
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    duty_buf_q[g] <= pwmpd_pkg::RST_WORD;
                end else if (load_q && period_end) begin
                    duty_buf_q[g] <= {duty_high_q[g], duty_low_q[g]};
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    gen_q[g] <= 1'b0;
                end else begin
                    gen_q[g] <= run_q && (cnt_q < duty_buf_q[g]);
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    o_pin_data[g] <= 1'b0;
                    o_pin_oe[g]   <= 1'b0;
                end else if (pin_sel_q[g]) begin
                    o_pin_data[g] <= gen_q[g];
                    o_pin_oe[g]   <= 1'b1;
                end else begin
                    o_pin_data[g] <= i_port_out[g];
                    o_pin_oe[g]   <= i_port_oe[g];
                end
            end
        end
    endgenerate

    assign o_generator_output_signal = gen_q;

    // ----------------------------------------
    // Clock source and prescaler
    // ----------------------------------------
    assign src_tick = clk_src_q ? i_timer1_ovf : 1'b1;
    assign tick     = run_q && src_tick &&
                      ((div_cnt_q & div_mask(i_clock_prescale_code)) == div_mask(i_clock_prescale_code));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            div_cnt_q <= pwmpd_pkg::RST_DIV;
        end else if (!run_q) begin
            div_cnt_q <= pwmpd_pkg::RST_DIV;
        end else if (src_tick) begin
            div_cnt_q <= div_cnt_q + pwmpd_pkg::DIV_ONE;
        end
    end

    // ----------------------------------------
    // Period counter and buffered load
    // ----------------------------------------
    assign period_end = tick && (cnt_q >= period_buf_q);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_q <= pwmpd_pkg::RST_WORD;
        end else if (period_end) begin
            cnt_q <= pwmpd_pkg::RST_WORD;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            period_buf_q <= pwmpd_pkg::RST_WORD;
        end else if (load_q && period_end) begin
            period_buf_q <= {period_high_q, period_low_q};
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_sfr_rdata <= pwmpd_pkg::RST_BYTE;
        end else if (rdec.hit) begin
            o_sfr_rdata <= rdec.high ? duty_high_q[rdec.ch] : duty_low_q[rdec.ch];
        end else begin
            case (i_sfr.addr)
                pwmpd_pkg::ADDR_CLOCK_CONTROL: o_sfr_rdata <= {1'b0, clk_src_q, 6'h00};
                pwmpd_pkg::ADDR_RUN_CONTROL:   o_sfr_rdata <= {run_q, load_q, 6'h00};
                pwmpd_pkg::ADDR_PERIOD_LOW:    o_sfr_rdata <= period_low_q;
                pwmpd_pkg::ADDR_PERIOD_HIGH:   o_sfr_rdata <= period_high_q;
                pwmpd_pkg::ADDR_PIN_SELECT:    o_sfr_rdata <= {2'b00, pin_sel_q};
                default:                       o_sfr_rdata <= pwmpd_pkg::RST_BYTE;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_load_due;
        load_q && period_end && !load_wr;
    endsequence

    sequence s_copied;
        !load_q && period_buf_q == $past({period_high_q, period_low_q}, 1);
    endsequence

    AST_RESET_ZERO: assert property ($fell(i_rst) |-> period_low_q == 8'h00 && period_high_q == 8'h00
                                     && pin_sel_q == 6'h00 && duty_low_q[5] == 8'h00)
        else $error("Registers not zero after reset");

    AST_LOAD_COPY: assert property (s_load_due |=> s_copied)
        else $error("Load did not copy or clear");

    AST_LOAD_HOLD: assert property (load_q && !period_end |=> load_q)
        else $error("Load cleared before period end");

    AST_IDLE: assert property (!run_q |=> $stable(cnt_q))
        else $error("Counter moved while idle");

    AST_WRAP: assert property (period_end |=> cnt_q == 16'h0000)
        else $error("Counter did not restart at period");

    AST_SYS_CLOCK: assert property (run_q && !clk_src_q && i_clock_prescale_code == 3'h0 |-> tick)
        else $error("System clock tick missing");

    AST_TIMER_SRC: assert property (clk_src_q && !i_timer1_ovf |-> !tick)
        else $error("Tick without Timer 1 overflow");

    AST_PAGED: assert property (i_sfr.wr && !i_sfr.page && i_sfr.addr == pwmpd_pkg::ADDR_DUTY_HIGH[4]
                                |=> $stable(duty_high_q[4]))
        else $error("Channel 4 duty written off page 1");

    AST_PIN_ROUTE: assert property (pin_sel_q[0] |=> o_pin_data[0] == $past(gen_q[0]) && o_pin_oe[0])
        else $error("Channel 0 not routed to pin");

    AST_DUTY_CMP: assert property (run_q ##1 run_q |-> gen_q[1] == $past(cnt_q < duty_buf_q[1]))
        else $error("Channel 1 compare wrong");

    AST_UNUSED_BITS: assert property (i_sfr.addr == pwmpd_pkg::ADDR_PIN_SELECT |=> o_sfr_rdata[7:6] == 2'b00)
        else $error("Unused pin select bits read nonzero");

endmodule : pwmpd_core

`default_nettype wire

// ==== src/pwmpd_pkg.sv ====
// Package: register map, field positions and bus carrier for the pulse-width front end
package pwmpd_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;
    localparam logic [7:0] ADDR_RUN_CONTROL   = 8'hD7;
    localparam logic [7:0] ADDR_PERIOD_LOW    = 8'hD9;
    localparam logic [7:0] ADDR_PERIOD_HIGH   = 8'hD1;
    localparam logic [7:0] ADDR_PIN_SELECT    = 8'hDE;
    localparam logic [7:0] ADDR_DUTY_HIGH [6] = '{8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hC4, 8'hC5};
    localparam logic [7:0] ADDR_DUTY_LOW  [6] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hCC, 8'hCD};

    // ----------------------------------------
    // Counts, fields and reset values
    // ----------------------------------------
    localparam int          NUM_CH           = 6;
    localparam int          FIRST_PAGED_CH   = 4;
    localparam int          BIT_CLK_SRC      = 6;
    localparam int          BIT_RUN          = 7;
    localparam int          BIT_LOAD         = 6;
    localparam int          PRESCALE_W       = 3;
    localparam int          DIV_CNT_W        = 7;
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [15:0] RST_WORD         = 16'h0000;
    localparam logic [5:0]  RST_SEL          = 6'h00;
    localparam logic [6:0]  RST_DIV          = 7'h00;
    localparam logic [6:0]  DIV_ONE          = 7'h01;
    localparam logic        PAGE_ONE         = 1'b1;

    // ----------------------------------------
    // Register access carrier
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic       page;
    } pwmpd_sfr_t;

    typedef struct packed {
        logic       hit;
        logic       high;
        logic [2:0] ch;
    } pwmpd_duty_dec_t;

endpackage : pwmpd_pkg
